// ===== include/wsg_pkg.sv
// Constants, register map and carrier types of the wait-state generator.
// Assumes a CPU bus that is synchronous to the system clock.
`default_nettype none
package wsg_pkg;

  //////////////////////////////////////////////////////////////////////////
  // I/O addresses of the indirect register access ports (low address byte)
  localparam logic [7:0] DATA_PORT_ADDR = 8'he0;
  localparam logic [7:0] INDEX_PORT_ADDR = 8'hee;
  // On-chip I/O registers occupy this low-byte range and are never stretched
  localparam logic [7:0] ONCHIP_IO_FIRST = 8'he0;

  //////////////////////////////////////////////////////////////////////////
  // Control register indices
  localparam logic [7:0] IDX_WAIT_CTL = 8'h00;
  localparam logic [7:0] IDX_MEM_WIN = 8'h01;
  localparam logic [7:0] IDX_CS_WIN = 8'h02;
  localparam logic [7:0] IDX_MISC = 8'h03;

  //////////////////////////////////////////////////////////////////////////
  // Reset and auto-clear values
  localparam logic [7:0] WAIT_CTL_RESET = 8'hff;
  localparam logic [7:0] MEM_WIN_RESET = 8'hff;
  localparam logic [7:0] CS_WIN_RESET = 8'h80;
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] AUTO_CLEAR_VALUE = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Field positions of wait_count_control
  localparam int ACK_MSB = 7;
  localparam int ACK_LSB = 6;
  localparam int VECTOR_BIT = 5;
  localparam int FETCH_EXT_BIT = 4;
  localparam int MEM_MSB = 3;
  localparam int MEM_LSB = 2;
  localparam int IO_MSB = 1;
  localparam int IO_LSB = 0;
  // Field positions of misc_options
  localparam int RETURN_MSB = 1;
  localparam int RETURN_LSB = 0;
  localparam int DAISY_MSB = 3;
  localparam int DAISY_LSB = 2;

  //////////////////////////////////////////////////////////////////////////
  // Timing counts
  localparam logic [4:0] FETCH_CLEAR_COUNT = 5'h10;
  localparam logic [3:0] ONE_WAIT = 4'h1;

  //////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic mem_request;
    logic io_request_strobe;
    logic rd;
    logic wr;
    logic opcode_fetch_indicator;
    logic int_return_cycle;
  } wsg_bus_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STRETCH,
    ST_HOLD
  } wsg_state_e;

endpackage
`default_nettype wire

// ===== rtl/wsg_wait_state_generator.sv
// Wait-state generator with indirect control registers and chip selects.
// Assumes bus inputs synchronous to clk; a bus cycle lasts while a request
// strobe is high, and the CPU samples cpu_wait once per clock.
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module wsg_wait_state_generator (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // CPU bus
  input wire wsg_pkg::wsg_bus_s bus,
  // Wait request to the CPU
  output logic cpu_wait,
  // Register read data
  output logic [7:0] rdata,
  output logic rdata_oe,
  // Chip selects
  output logic [1:0] chip_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Field decoders
  function automatic logic [3:0] ack_waits(input logic [1:0] code);
    case (code)
      2'b00: ack_waits = 4'h0;
      2'b01: ack_waits = 4'h2;
      2'b10: ack_waits = 4'h4;
      default: ack_waits = 4'h6;
    endcase
  endfunction

  function automatic logic [3:0] daisy_waits(input logic [1:0] code);
    case (code)
      2'b00: daisy_waits = 4'h0;
      2'b01: daisy_waits = 4'h1;
      2'b10: daisy_waits = 4'h2;
      default: daisy_waits = 4'h4;
    endcase
  endfunction

  function automatic logic [3:0] plain_waits(input logic [1:0] code);
    plain_waits = {2'b00, code};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] wait_ctl, next_wait_ctl;
  logic [7:0] mem_win, next_mem_win;
  logic [7:0] cs_win, next_cs_win;
  logic [7:0] misc, next_misc;
  logic [7:0] index, next_index;
  logic programmed, next_programmed;
  logic [4:0] fetch_count, next_fetch_count;
  logic cyc_q, next_cyc_q;
  logic fetch_q, next_fetch_q;
  wsg_pkg::wsg_state_e state, next_state;
  logic [3:0] count, next_count;
  logic next_cpu_wait;
  logic [7:0] next_rdata;
  logic next_rdata_oe;
  logic [1:0] next_chip_sel;

  // Bus event decode
  logic cyc;
  logic start;
  logic io_plain;
  logic io_wr_start;
  logic io_rd_start;
  logic fetch_fall;
  logic [7:0] lo;
  logic [3:0] n_waits;

  assign lo = bus.addr[7:0];
  assign cyc = bus.mem_request | bus.io_request_strobe;
  assign start = cyc & ~cyc_q;
  assign io_plain = bus.io_request_strobe & ~bus.opcode_fetch_indicator;
  assign io_wr_start = start & io_plain & bus.wr;
  assign io_rd_start = start & io_plain & bus.rd;
  assign fetch_fall = fetch_q & ~bus.opcode_fetch_indicator;

  ////////////////////////////////////////////////////////////////////////////
  // Wait count for the cycle now starting
  always_comb begin
    n_waits = 4'h0;
    if (bus.io_request_strobe && bus.opcode_fetch_indicator) begin
      n_waits = ack_waits(wait_ctl[wsg_pkg::ACK_MSB:wsg_pkg::ACK_LSB])
        + daisy_waits(misc[wsg_pkg::DAISY_MSB:wsg_pkg::DAISY_LSB]);
      if (wait_ctl[wsg_pkg::VECTOR_BIT]) begin
        n_waits = n_waits + wsg_pkg::ONE_WAIT;
      end
    end else if (bus.io_request_strobe) begin
      if (lo < wsg_pkg::ONCHIP_IO_FIRST) begin
        n_waits = plain_waits(
          wait_ctl[wsg_pkg::IO_MSB:wsg_pkg::IO_LSB]);
      end else begin
        n_waits = 4'h0;
      end
    end else if (bus.mem_request) begin
      if (bus.addr[15:8] <= mem_win) begin
        n_waits = plain_waits(
          wait_ctl[wsg_pkg::MEM_MSB:wsg_pkg::MEM_LSB]);
      end
      if (bus.opcode_fetch_indicator && wait_ctl[wsg_pkg::FETCH_EXT_BIT]) begin
        n_waits = n_waits + wsg_pkg::ONE_WAIT;
      end
      if (bus.int_return_cycle) begin
        n_waits = n_waits
          + plain_waits(misc[wsg_pkg::RETURN_MSB:wsg_pkg::RETURN_LSB]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stretch sequencer
  always_comb begin
    next_state = state;
    next_count = count;
    next_cpu_wait = cpu_wait;
    next_cyc_q = cyc;
    next_fetch_q = bus.opcode_fetch_indicator;
    case (state)
      wsg_pkg::ST_IDLE: begin
        if (start) begin
          next_count = n_waits;
          next_cpu_wait = (n_waits != 4'h0);
          next_state = (n_waits != 4'h0) ? wsg_pkg::ST_STRETCH
                                         : wsg_pkg::ST_HOLD;
        end
      end
      wsg_pkg::ST_STRETCH: begin
        if (count == wsg_pkg::ONE_WAIT) begin
          next_cpu_wait = 1'b0;
          next_count = 4'h0;
          next_state = wsg_pkg::ST_HOLD;
        end else begin
          next_count = count - wsg_pkg::ONE_WAIT;
        end
      end
      default: begin
        next_cpu_wait = 1'b0;
        if (!cyc) begin
          next_state = wsg_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= wsg_pkg::ST_IDLE;
      count <= 4'h0;
      cpu_wait <= 1'b0;
      cyc_q <= 1'b0;
      fetch_q <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      cpu_wait <= next_cpu_wait;
      cyc_q <= next_cyc_q;
      fetch_q <= next_fetch_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, indirect access and power-on auto clear
  always_comb begin
    next_wait_ctl = wait_ctl;
    next_mem_win = mem_win;
    next_cs_win = cs_win;
    next_misc = misc;
    next_index = index;
    next_programmed = programmed;
    next_fetch_count = fetch_count;
    if (fetch_fall && fetch_count != wsg_pkg::FETCH_CLEAR_COUNT) begin
      next_fetch_count = fetch_count + 5'h01;
      if (next_fetch_count == wsg_pkg::FETCH_CLEAR_COUNT && !programmed) begin
        next_wait_ctl = wsg_pkg::AUTO_CLEAR_VALUE;
      end
    end
    if (io_wr_start && lo == wsg_pkg::INDEX_PORT_ADDR) begin
      next_index = bus.wdata;
    end else if (io_wr_start && lo == wsg_pkg::DATA_PORT_ADDR) begin
      if (index == wsg_pkg::IDX_WAIT_CTL) begin
        next_wait_ctl = bus.wdata;
        next_programmed = 1'b1;
      end else if (index == wsg_pkg::IDX_MEM_WIN) begin
        next_mem_win = bus.wdata;
      end else if (index == wsg_pkg::IDX_CS_WIN) begin
        next_cs_win = bus.wdata;
      end else if (index == wsg_pkg::IDX_MISC) begin
        next_misc = bus.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wait_ctl <= wsg_pkg::WAIT_CTL_RESET;
      mem_win <= wsg_pkg::MEM_WIN_RESET;
      cs_win <= wsg_pkg::CS_WIN_RESET;
      misc <= wsg_pkg::MISC_RESET;
      index <= wsg_pkg::INDEX_RESET;
      programmed <= 1'b0;
      fetch_count <= 5'h00;
    end else begin
      wait_ctl <= next_wait_ctl;
      mem_win <= next_mem_win;
      cs_win <= next_cs_win;
      misc <= next_misc;
      index <= next_index;
      programmed <= next_programmed;
      fetch_count <= next_fetch_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and chip selects
  always_comb begin
    next_rdata = rdata;
    next_rdata_oe = rdata_oe & cyc;
    if (io_rd_start && lo == wsg_pkg::INDEX_PORT_ADDR) begin
      next_rdata = index;
      next_rdata_oe = 1'b1;
    end else if (io_rd_start && lo == wsg_pkg::DATA_PORT_ADDR) begin
      next_rdata_oe = 1'b1;
      if (index == wsg_pkg::IDX_WAIT_CTL) begin
        next_rdata = wait_ctl;
      end else if (index == wsg_pkg::IDX_MEM_WIN) begin
        next_rdata = mem_win;
      end else if (index == wsg_pkg::IDX_CS_WIN) begin
        next_rdata = cs_win;
      end else if (index == wsg_pkg::IDX_MISC) begin
        next_rdata = misc;
      end else begin
        next_rdata = 8'h00;
      end
    end
    if (!bus.mem_request) begin
      next_chip_sel = 2'b00;
    end else if (bus.addr[15:8] < cs_win) begin
      next_chip_sel = 2'b01;
    end else begin
      next_chip_sel = 2'b10;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 8'h00;
      rdata_oe <= 1'b0;
      chip_sel <= 2'b00;
    end else begin
      rdata <= next_rdata;
      rdata_oe <= next_rdata_oe;
      chip_sel <= next_chip_sel;
    end
  end

endmodule

`default_nettype wire

// ===== verification/wsg_chk.sv
// Port checker of the wait-state generator, bound into its top module.
// Assumes bus cycles are separated by at least one idle clock.
`timescale 1ns/1ps
`default_nettype none
module wsg_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched ports
  input wire wsg_pkg::wsg_bus_s bus,
  input wire logic cpu_wait,
  input wire logic [7:0] rdata,
  input wire logic rdata_oe,
  input wire logic [1:0] chip_sel
);
  logic cyc, cyc_q, st, opf_q, wrote, next_wrote;
  logic [3:0] wcnt, next_wcnt;
  logic [4:0] fcnt, next_fcnt;
  assign cyc = bus.mem_request | bus.io_request_strobe;
  assign st = cyc & ~cyc_q;
  always_comb begin
    next_wcnt = cpu_wait ? wcnt + 4'h1 : 4'h0;
    next_fcnt = fcnt + {4'h0, opf_q & ~bus.opcode_fetch_indicator};
    next_wrote = wrote | (st & bus.wr);
  end
  always_ff @(posedge clk) begin
    cyc_q <= nrst & cyc;
    opf_q <= nrst & bus.opcode_fetch_indicator;
    wcnt <= nrst ? next_wcnt : 4'h0;
    fcnt <= nrst ? next_fcnt : 5'h00;
    wrote <= nrst & next_wrote;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_reset_quiet: assert property (disable iff (1'b0)
    !nrst |=> !cpu_wait && !rdata_oe && chip_sel == 2'h0)
    else $error("outputs active after reset");
  a_wait_contig: assert property (
    cpu_wait |-> $past(cpu_wait) || $past(st))
    else $error("wait not tied to a cycle start");
  a_wait_bound: assert property (wcnt < 4'hc)
    else $error("wait longer than eleven clocks");
  a_onchip_nowait: assert property (
    st && bus.io_request_strobe && !bus.opcode_fetch_indicator &&
    bus.addr[7:0] >= wsg_pkg::ONCHIP_IO_FIRST |=> !cpu_wait)
    else $error("on-chip access stretched");
  a_fetch_maxwait: assert property (
    st && bus.mem_request && bus.opcode_fetch_indicator &&
    fcnt < 5'h0f && !wrote |=> cpu_wait [*4] ##1 !cpu_wait)
    else $error("fetch not held four clocks");
  a_read_answer: assert property (
    st && bus.io_request_strobe && bus.rd && !bus.opcode_fetch_indicator
    && bus.addr[7:0] == wsg_pkg::DATA_PORT_ADDR |=> rdata_oe)
    else $error("data port read not answered");
  a_oe_release: assert property (!cyc |=> !rdata_oe)
    else $error("read data driven outside a cycle");
  a_cs_idle: assert property (!bus.mem_request |=> chip_sel == 2'h0)
    else $error("chip select outside memory cycle");
  a_cs_onehot: assert property (
    bus.mem_request |=> $onehot(chip_sel))
    else $error("chip select not one-hot");
  c_int_ack: cover property (st && bus.io_request_strobe &&
    bus.opcode_fetch_indicator);
  c_read: cover property ($rose(rdata_oe));
  c_low_cs: cover property (chip_sel == 2'h1);
endmodule
bind wsg_wait_state_generator wsg_chk u_wsg_chk (.clk(clk), .nrst(nrst),
  .bus(bus), .cpu_wait(cpu_wait), .rdata(rdata), .rdata_oe(rdata_oe),
  .chip_sel(chip_sel));
`default_nettype wire

// ===== verification/wsg_cpu_model.sv
// CPU bus model: one bus cycle per start pulse, held while cpu_wait is high.
// Assumes start comes only after done was seen for the previous cycle.
`timescale 1ns/1ps
`default_nettype none
module wsg_cpu_model (
  // Clock
  input wire logic clk,
  // Command from the bench
  input wire logic start,
  input wire wsg_pkg::wsg_bus_s req,
  // Generator side
  output wsg_pkg::wsg_bus_s bus,
  input wire logic cpu_wait,
  input wire logic [7:0] rdata,
  input wire logic [1:0] chip_sel,
  // Outcome of the last cycle
  output logic done,
  output logic [3:0] waits,
  output logic [7:0] rd_val,
  output logic [1:0] cs_val
);
  logic [1:0] ph;
  initial begin
    bus = '0;
    ph = 2'h0;
    done = 1'b0;
    waits = 4'h0;
    rd_val = 8'h00;
    cs_val = 2'h0;
  end
  always @(posedge clk) begin
    done <= 1'b0;
    case (ph)
      2'h0: if (start) begin
        bus <= req;
        waits <= 4'h0;
        ph <= 2'h1;
      end else begin
        // Released address and data lines wander so no stale value is trusted
        bus.addr <= ~bus.addr;
        bus.wdata <= ~bus.wdata;
      end
      2'h1: ph <= 2'h2;
      2'h2: if (cpu_wait) begin
        waits <= waits + 4'h1;
      end else begin
        rd_val <= rdata;
        cs_val <= chip_sel;
        bus <= '0;
        done <= 1'b1;
        ph <= 2'h3;
      end
      default: ph <= 2'h0;
    endcase
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench of the wait-state generator with a CPU bus model.
// Assumes every bus cycle ends within forty clocks.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, nrst, start, cpu_wait, rdata_oe, done;
  logic [7:0] rdata, rd_val, wait_count_control, misc, mwin, cswin;
  logic [3:0] waits;
  logic [1:0] chip_sel, cs_val;
  logic [7:0] rst_tab [4] = '{wsg_pkg::MEM_WIN_RESET,
    wsg_pkg::CS_WIN_RESET, wsg_pkg::MISC_RESET, 8'h00};
  wsg_pkg::wsg_bus_s bus, req, r;
  int n_errors, n_compared, i;
  wsg_wait_state_generator u_wsg_wait_state_generator (.clk(clk),
    .nrst(nrst), .bus(bus), .cpu_wait(cpu_wait), .rdata(rdata),
    .rdata_oe(rdata_oe), .chip_sel(chip_sel));
  wsg_cpu_model u_wsg_cpu_model (.clk(clk), .start(start), .req(req),
    .bus(bus), .cpu_wait(cpu_wait), .rdata(rdata), .chip_sel(chip_sel),
    .done(done), .waits(waits), .rd_val(rd_val), .cs_val(cs_val));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input wsg_pkg::wsg_bus_s c);
    int k;
    req <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge clk);
    if (done !== 1'b1) begin
      n_errors++;
      $display("Error %0t: bus cycle hung", $time);
      report_and_stop();
    end
  endtask
  function automatic logic [7:0] exp_w(input wsg_pkg::wsg_bus_s b);
    int n;
    if (b.io_request_strobe && b.opcode_fetch_indicator) begin
      n = 2 * wait_count_control[7:6] + (misc[3:2] == 2'h3 ? 4 : misc[3:2]) + wait_count_control[5];
    end else if (b.io_request_strobe) begin
      n = b.addr[7:0] < wsg_pkg::ONCHIP_IO_FIRST ? wait_count_control[1:0] : 0;
    end else begin
      n = (b.addr[15:8] <= mwin ? wait_count_control[3:2] : 0) + (b.int_return_cycle ?
        misc[1:0] : 0) + (b.opcode_fetch_indicator ? wait_count_control[4] : 0);
    end
    return n[7:0];
  endfunction
  function automatic logic [7:0] exp_cs(input wsg_pkg::wsg_bus_s b);
    if (!b.mem_request) begin
      return 8'h00;
    end
    return (b.addr[15:8] < cswin) ? 8'h01 : 8'h02;
  endfunction
  task automatic io(input logic [7:0] a, input logic [7:0] d, input bit w);
    wsg_pkg::wsg_bus_s c;
    c = '0;
    c.addr = {8'h00, a};
    c.wdata = d;
    c.io_request_strobe = 1'b1;
    c.wr = w;
    c.rd = !w;
    run(c);
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    io(wsg_pkg::INDEX_PORT_ADDR, idx, 1'b1);
    io(wsg_pkg::DATA_PORT_ADDR, d, 1'b1);
  endtask
  task automatic fetches(input int cnt);
    repeat (cnt) begin
      r = '0;
      r.addr = 16'($urandom);
      r.mem_request = 1'b1;
      r.rd = 1'b1;
      r.opcode_fetch_indicator = 1'b1;
      run(r);
      check({4'h0, waits}, exp_w(r));
      check({6'h00, cs_val}, exp_cs(r));
    end
  endtask
  initial begin
    nrst = 1'b0;
    start = 1'b0;
    req = '0;
    n_errors = 0;
    n_compared = 0;
    wait_count_control = wsg_pkg::WAIT_CTL_RESET;
    misc = wsg_pkg::MISC_RESET;
    mwin = wsg_pkg::MEM_WIN_RESET;
    cswin = wsg_pkg::CS_WIN_RESET;
    void'($urandom(91));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    fetches(15);
    io(wsg_pkg::DATA_PORT_ADDR, 8'h00, 1'b0);
    check(rd_val, wsg_pkg::WAIT_CTL_RESET);
    fetches(1);
    wait_count_control = wsg_pkg::AUTO_CLEAR_VALUE;
    io(wsg_pkg::DATA_PORT_ADDR, 8'h00, 1'b0);
    check(rd_val, wait_count_control);
    for (i = 1; i < 5; i++) begin
      io(wsg_pkg::INDEX_PORT_ADDR, 8'(i), 1'b1);
      io(wsg_pkg::DATA_PORT_ADDR, 8'h00, 1'b0);
      check(rd_val, rst_tab[i-1]);
    end
    for (i = 0; i < 72; i++) begin
      if (i % 6 == 0) begin
        wait_count_control = 8'($urandom);
        misc = 8'($urandom);
        mwin = 8'($urandom);
        reg_wr(wsg_pkg::IDX_MISC, misc);
        reg_wr(wsg_pkg::IDX_MEM_WIN, mwin);
        cswin = 8'($urandom);
        reg_wr(wsg_pkg::IDX_CS_WIN, cswin);
        reg_wr(wsg_pkg::IDX_WAIT_CTL, wait_count_control);
        io(wsg_pkg::DATA_PORT_ADDR, 8'h00, 1'b0);
        check(rd_val, wait_count_control);
      end
      r = '0;
      r.addr = 16'($urandom);
      if (i % 3 == 0) begin
        r.addr[15:8] = mwin + 8'($urandom % 2);
      end
      r.rd = 1'b1;
      case (i % 4)
        0: begin
          r.io_request_strobe = 1'b1;
          r.opcode_fetch_indicator = 1'b1;
          r.rd = 1'b0;
        end
        1: begin
          r.io_request_strobe = 1'b1;
          if (i % 8 == 1) begin
            r.addr[7:0] = 8'hf0;
          end
        end
        default: begin
          r.mem_request = 1'b1;
          r.opcode_fetch_indicator = 1'($urandom);
          r.int_return_cycle = 1'($urandom);
          if (i % 8 == 2) begin
            r.addr[15:8] = cswin - 8'($urandom % 2);
          end
        end
      endcase
      run(r);
      check({4'h0, waits}, exp_w(r));
      check({6'h00, cs_val}, exp_cs(r));
    end
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wait_count_control = 8'h5a;
    misc = wsg_pkg::MISC_RESET;
    mwin = wsg_pkg::MEM_WIN_RESET;
    cswin = wsg_pkg::CS_WIN_RESET;
    reg_wr(wsg_pkg::IDX_WAIT_CTL, wait_count_control);
    fetches(16);
    io(wsg_pkg::DATA_PORT_ADDR, 8'h00, 1'b0);
    check(rd_val, wait_count_control);
    report_and_stop();
  end
endmodule
`default_nettype wire
